// ### design/ssr_service_request.v
// Service-request collector and management statistics for a multi-port
// circuit emulation reassembly device, with an AXI4-Lite register slave.
// Assumes every event input is a one-cycle pulse from logic on core_clk.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "ssr_regs.vh"

module ssr_service_request #(
  parameter NPORT = 8,
  parameter NVC = 256,
  parameter VC_W = 8,
  parameter SADDR_W = 10,
  parameter CHAN_W = 5
) (
  input wire core_clk,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire mem_parity_err,
  input wire cell_cnt_roll,
  input wire parity_cnt_roll,
  input wire tx_data_empty,
  input wire rx_data_arrive,
  input wire rx_data_overrun,
  input wire rx_data_half,
  input wire rx_data_roll,
  input wire [`SSR_UNST_W-1:0] unst_roll,
  input wire [2:0] unst_roll_port,
  input wire [`SSR_STRC_ROLL_W-1:0] strc_roll,
  input wire strc_ptr_oor,
  input wire strc_sig_changed,
  input wire [SADDR_W-1:0] strc_struct_addr,
  input wire vc_cell_arrive,
  input wire [VC_W-1:0] vc_cell_index,
  input wire [NPORT-1:0] unst_port_arrive,
  input wire [NPORT-1:0] port_los,
  input wire [NPORT-1:0] port_obuf_err,
  input wire [NPORT-1:0] port_simple_under,
  input wire [NPORT-1:0] port_perm_under,
  input wire [CHAN_W*NPORT-1:0] port_under_chan,
  output reg irq_n_out,
  output reg irq_n_oe
);

  localparam integer TICK_CYC = (`SSR_TICK_NS + `SSR_CLK_NS - 1) / `SSR_CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave.

  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_go;
  wire [31:0] wmask;
  wire [31:0] wdm;
  wire [7:0] wa;
  wire [2:0] widx;
  reg [31:0] rd_mux;
  reg rd_hit;
  reg wr_hit;

  // Expand the byte strobes so every register but the arrival register honours partial writes.
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wdm = w_data & wmask;
  assign wa = {aw_addr[7:2], 2'b00};
  assign widx = aw_addr[4:2];
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  // Address and data are caught in either order; the response follows both.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `SSR_RESP_OKAY : `SSR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // One read at a time; unmapped addresses answer zero with SLVERR.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SSR_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `SSR_RESP_OKAY : `SSR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared registers.

  reg [`SSR_MISC_W-1:0] stat_misc;
  reg [`SSR_MISC_W-1:0] en_misc;
  reg [`SSR_UNST_W-1:0] stat_unst;
  reg [`SSR_UNST_W-1:0] en_unst;
  reg [`SSR_STRC_W-1:0] stat_strc;
  reg [`SSR_STRC_W-1:0] en_strc;
  reg sig_mode;
  reg [NPORT-1:0] port_mode;
  reg [2:0] last_unst_port;
  reg [SADDR_W-1:0] last_strc_addr;
  reg [15:0] late_to;
  reg [15:0] cut_to;
  reg [VC_W-1:0] arr_index;
  reg arrival_mem [0:NVC-1];
  reg [`SSR_MISC_W-1:0] set_misc;
  wire [`SSR_STRC_W-1:0] set_strc;
  wire wr_misc;
  wire wr_unst;
  wire wr_strc;
  wire wr_arr;

  assign wr_misc = wr_go && (wa == `SSR_STAT_MISC);
  assign wr_unst = wr_go && (wa == `SSR_STAT_UNST);
  assign wr_strc = wr_go && (wa == `SSR_STAT_STRC);
  assign wr_arr = wr_go && (wa == `SSR_ARRIVAL);

  // Gather the module-level sources into the miscellaneous status layout.
  always @* begin
    set_misc = {`SSR_MISC_W{1'b0}};
    set_misc[`SSR_MISC_MEM_PAR] = mem_parity_err;
    set_misc[`SSR_MISC_CELL_ROLL] = cell_cnt_roll;
    set_misc[`SSR_MISC_PAR_ROLL] = parity_cnt_roll;
    set_misc[`SSR_MISC_TX_EMPTY] = tx_data_empty;
    set_misc[`SSR_MISC_RX_ARRIVE] = rx_data_arrive;
    set_misc[`SSR_MISC_RX_OVERRUN] = rx_data_overrun;
    set_misc[`SSR_MISC_RX_HALF] = rx_data_half;
    set_misc[`SSR_MISC_RX_ROLL] = rx_data_roll;
  end

  // Signalling-changed only counts while signalling mode is on.
  assign set_strc = {strc_sig_changed & sig_mode, strc_ptr_oor, strc_roll};

  // Sticky status with write-one-to-clear; a new event wins over its clear.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      stat_misc <= {`SSR_MISC_W{1'b0}};
      stat_unst <= {`SSR_UNST_W{1'b0}};
      stat_strc <= {`SSR_STRC_W{1'b0}};
    end else begin
      stat_misc <= (stat_misc & ~(wr_misc ? wdm[`SSR_MISC_W-1:0] : 8'h00)) | set_misc;
      stat_unst <= (stat_unst & ~(wr_unst ? wdm[`SSR_UNST_W-1:0] : 9'h000)) | unst_roll;
      stat_strc <= (stat_strc & ~(wr_strc ? wdm[`SSR_STRC_W-1:0] : 12'h000)) | set_strc;
    end
  end

  // Plain read-write configuration registers.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      en_misc <= {`SSR_MISC_W{1'b0}};
      en_unst <= {`SSR_UNST_W{1'b0}};
      en_strc <= {`SSR_STRC_W{1'b0}};
      sig_mode <= 1'b0;
      port_mode <= {NPORT{1'b0}};
      late_to <= `SSR_LATE_TO_RST;
      cut_to <= `SSR_CUT_TO_RST;
    end else if (wr_go) begin
      if (wa == `SSR_EN_MISC) begin
        en_misc <= (en_misc & ~wmask[`SSR_MISC_W-1:0]) | wdm[`SSR_MISC_W-1:0];
      end else if (wa == `SSR_EN_UNST) begin
        en_unst <= (en_unst & ~wmask[`SSR_UNST_W-1:0]) | wdm[`SSR_UNST_W-1:0];
      end else if (wa == `SSR_EN_STRC) begin
        en_strc <= (en_strc & ~wmask[`SSR_STRC_W-1:0]) | wdm[`SSR_STRC_W-1:0];
      end else if (wa == `SSR_CTRL) begin
        if (w_strb[0]) begin
          sig_mode <= w_data[`SSR_CTRL_SIG_MODE];
        end
      end else if (wa == `SSR_PORT_MODE) begin
        port_mode <= (port_mode & ~wmask[NPORT-1:0]) | wdm[NPORT-1:0];
      end else if (wa == `SSR_LATE_TO) begin
        late_to <= (late_to & ~wmask[15:0]) | wdm[15:0];
      end else if (wa == `SSR_CUT_TO) begin
        cut_to <= (cut_to & ~wmask[15:0]) | wdm[15:0];
      end
    end
  end

  // Last-event records follow only rollovers whose enable is set.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      last_unst_port <= 3'h0;
      last_strc_addr <= {SADDR_W{1'b0}};
    end else begin
      if (|(unst_roll & en_unst)) begin
        last_unst_port <= unst_roll_port;
      end
      if (|(strc_roll & en_strc[`SSR_STRC_ROLL_W-1:0])) begin
        last_strc_addr <= strc_struct_addr;
      end
    end
  end

  // Per-circuit arrival flags; writing with the clear bit drops the flag.
  integer vi;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      arr_index <= {VC_W{1'b0}};
      for (vi = 0; vi < NVC; vi = vi + 1) begin
        arrival_mem[vi] <= 1'b0;
      end
    end else begin
      if (wr_arr) begin
        arr_index <= w_data[VC_W-1:0];
        if (w_data[`SSR_ARR_CLEAR]) begin
          arrival_mem[w_data[VC_W-1:0]] <= 1'b0;
        end
      end
      if (vc_cell_arrive) begin
        arrival_mem[vc_cell_index] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Microsecond tick for the reassembly timeouts.

  reg [15:0] tick_cnt;
  reg tick;

  // Divider producing a one-cycle enable per tick period.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYC[15:0] - 16'h0001) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port alarms, timeouts and underrun statistics.

  wire [`SSR_PS_W*NPORT-1:0] pstat_flat;
  wire [`SSR_PS_W*NPORT-1:0] pen_flat;
  wire [CHAN_W*NPORT-1:0] psimple_flat;
  wire [32*NPORT-1:0] pperm_flat;
  wire [NPORT-1:0] ppend;

  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1) begin : g_port
      reg [`SSR_PS_W-1:0] stat;
      reg [`SSR_PS_W-1:0] en;
      reg [CHAN_W-1:0] simple_ch;
      reg [31:0] perm_map;
      reg [15:0] to_cnt;
      wire strc_mode;
      wire [15:0] nxt;
      wire late_hit;
      wire cut_hit;
      wire [`SSR_PS_W-1:0] set;
      wire [CHAN_W-1:0] ch;
      wire sel;

      assign strc_mode = port_mode[p];
      assign ch = port_under_chan[CHAN_W*p +: CHAN_W];
      // Widen the index rather than slicing the loop variable.
      assign sel = ({29'h00000000, widx} == p);
      assign nxt = to_cnt + 16'h0001;
      assign late_hit = tick && !strc_mode && (nxt == late_to);
      assign cut_hit = tick && !strc_mode && (nxt == cut_to);
      // Mode decides which alarms the port can raise.
      assign set = {late_hit, cut_hit, port_perm_under[p] & strc_mode,
                    port_simple_under[p] & strc_mode, port_obuf_err[p] & strc_mode,
                    port_obuf_err[p] & !strc_mode, port_los[p] & !strc_mode};

      // Idle timer restarts on each cell and stops counting once saturated.
      always @(posedge core_clk) begin
        if (!rst_b || strc_mode || unst_port_arrive[p]) begin
          to_cnt <= 16'h0000;
        end else if (tick && to_cnt != 16'hffff) begin
          to_cnt <= nxt;
        end
      end

      // Sticky port status, enable and underrun statistics.
      always @(posedge core_clk) begin
        if (!rst_b) begin
          stat <= {`SSR_PS_W{1'b0}};
          en <= {`SSR_PS_W{1'b0}};
          simple_ch <= {CHAN_W{1'b0}};
          perm_map <= 32'h00000000;
        end else begin
          stat <= (stat & ~((wr_go && sel && wa[7:5] == `SSR_PORT_STAT) ?
                  wdm[`SSR_PS_W-1:0] : 7'h00)) | set;
          if (wr_go && sel && wa[7:5] == `SSR_PORT_EN) begin
            en <= (en & ~wmask[`SSR_PS_W-1:0]) | wdm[`SSR_PS_W-1:0];
          end
          if (port_simple_under[p] && strc_mode) begin
            simple_ch <= ch;
          end
          perm_map <= (perm_map & ~((wr_go && sel && wa[7:5] == `SSR_PORT_PERM) ?
                      wdm : 32'h00000000)) |
                      ((port_perm_under[p] && strc_mode) ? (32'h00000001 << ch) :
                      32'h00000000);
        end
      end

      assign pstat_flat[`SSR_PS_W*p +: `SSR_PS_W] = stat;
      assign pen_flat[`SSR_PS_W*p +: `SSR_PS_W] = en;
      assign psimple_flat[CHAN_W*p +: CHAN_W] = simple_ch;
      assign pperm_flat[32*p +: 32] = perm_map;
      assign ppend[p] = |(stat & en);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output and read decode.

  wire pending;

  assign pending = (|(stat_misc & en_misc)) | (|(stat_unst & en_unst)) |
                   (|(stat_strc & en_strc)) | (|ppend);

  // Open drain: pull low only while an enabled request is latched.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      irq_n_out <= 1'b0;
      irq_n_oe <= 1'b0;
    end else begin
      irq_n_out <= 1'b0;
      irq_n_oe <= pending;
    end
  end

  // Write hit check shares the decode shape of the read side.
  always @* begin
    wr_hit = 1'b1;
    if (wa[7:5] == 3'h0 || wa[7:5] == 3'h1) begin
      wr_hit = (wa <= `SSR_PENDING);
    end else if (wa[7:5] > `SSR_PORT_PERM || widx >= NPORT) begin
      wr_hit = 1'b0;
    end
  end

  wire [7:0] ra;
  wire [2:0] ridx;
  assign ra = {s_axi_araddr[7:2], 2'b00};
  assign ridx = s_axi_araddr[4:2];

  // Read data multiplexer; reserved bits read as zero.
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    if (ra == `SSR_STAT_MISC) begin
      rd_mux[`SSR_MISC_W-1:0] = stat_misc;
    end else if (ra == `SSR_EN_MISC) begin
      rd_mux[`SSR_MISC_W-1:0] = en_misc;
    end else if (ra == `SSR_STAT_UNST) begin
      rd_mux[`SSR_UNST_W-1:0] = stat_unst;
    end else if (ra == `SSR_EN_UNST) begin
      rd_mux[`SSR_UNST_W-1:0] = en_unst;
    end else if (ra == `SSR_STAT_STRC) begin
      rd_mux[`SSR_STRC_W-1:0] = stat_strc;
    end else if (ra == `SSR_EN_STRC) begin
      rd_mux[`SSR_STRC_W-1:0] = en_strc;
    end else if (ra == `SSR_CTRL) begin
      rd_mux[`SSR_CTRL_SIG_MODE] = sig_mode;
    end else if (ra == `SSR_PORT_MODE) begin
      rd_mux[NPORT-1:0] = port_mode;
    end else if (ra == `SSR_LAST_UNST) begin
      rd_mux[2:0] = last_unst_port;
    end else if (ra == `SSR_LAST_STRC) begin
      rd_mux[SADDR_W-1:0] = last_strc_addr;
    end else if (ra == `SSR_LATE_TO) begin
      rd_mux[15:0] = late_to;
    end else if (ra == `SSR_CUT_TO) begin
      rd_mux[15:0] = cut_to;
    end else if (ra == `SSR_ARRIVAL) begin
      rd_mux[VC_W-1:0] = arr_index;
      rd_mux[`SSR_ARR_FLAG] = arrival_mem[arr_index];
    end else if (ra == `SSR_PENDING) begin
      rd_mux[0] = pending;
    end else if (ridx >= NPORT) begin
      rd_hit = 1'b0;
    end else if (ra[7:5] == `SSR_PORT_STAT) begin
      rd_mux[`SSR_PS_W-1:0] = pstat_flat[`SSR_PS_W*ridx +: `SSR_PS_W];
    end else if (ra[7:5] == `SSR_PORT_EN) begin
      rd_mux[`SSR_PS_W-1:0] = pen_flat[`SSR_PS_W*ridx +: `SSR_PS_W];
    end else if (ra[7:5] == `SSR_PORT_SIMPLE) begin
      rd_mux[CHAN_W-1:0] = psimple_flat[CHAN_W*ridx +: CHAN_W];
    end else if (ra[7:5] == `SSR_PORT_PERM) begin
      rd_mux = pperm_flat[32*ridx +: 32];
    end else begin
      rd_hit = 1'b0;
    end
  end

endmodule // ssr_service_request

// ### design/ssr_regs.vh
// Register offsets, field positions, reset values and timing counts of the
// service-request and statistics block.
// Assumes a byte-addressed AXI4-Lite slave with one 32-bit word per register.
`ifndef SSR_REGS_VH
`define SSR_REGS_VH
// Register byte offsets.
`define SSR_STAT_MISC 8'h00
`define SSR_EN_MISC 8'h04
`define SSR_STAT_UNST 8'h08
`define SSR_EN_UNST 8'h0c
`define SSR_STAT_STRC 8'h10
`define SSR_EN_STRC 8'h14
`define SSR_CTRL 8'h18
`define SSR_PORT_MODE 8'h1c
`define SSR_LAST_UNST 8'h20
`define SSR_LAST_STRC 8'h24
`define SSR_LATE_TO 8'h28
`define SSR_CUT_TO 8'h2c
`define SSR_ARRIVAL 8'h30
`define SSR_PENDING 8'h34
// Per-port register banks, one word per port, eight ports per bank.
`define SSR_PORT_STAT 3'h2
`define SSR_PORT_EN 3'h3
`define SSR_PORT_SIMPLE 3'h4
`define SSR_PORT_PERM 3'h5
// Miscellaneous status bits.
`define SSR_MISC_MEM_PAR 0
`define SSR_MISC_CELL_ROLL 1
`define SSR_MISC_PAR_ROLL 2
`define SSR_MISC_TX_EMPTY 3
`define SSR_MISC_RX_ARRIVE 4
`define SSR_MISC_RX_OVERRUN 5
`define SSR_MISC_RX_HALF 6
`define SSR_MISC_RX_ROLL 7
`define SSR_MISC_W 8
// Unstructured rollover bits 0..8: cells, header, sequence, lost, misinserted,
// write underrun, write overrun, late, overall.
`define SSR_UNST_W 9
// Structured bits 0..9 rollovers: cells, header, sequence, lost, misinserted,
// reframe, pointer parity, write underrun, write overrun, overall.
`define SSR_STRC_ROLL_W 10
`define SSR_STRC_OOR 10
`define SSR_STRC_SIG 11
`define SSR_STRC_W 12
// Per-port status bits.
`define SSR_PS_LOS 0
`define SSR_PS_UOBUF 1
`define SSR_PS_SOBUF 2
`define SSR_PS_SIMPLE 3
`define SSR_PS_PERM 4
`define SSR_PS_CUT 5
`define SSR_PS_LATE 6
`define SSR_PS_W 7
// Control bits and arrival access fields.
`define SSR_CTRL_SIG_MODE 0
`define SSR_ARR_CLEAR 31
`define SSR_ARR_FLAG 8
// Reset values of the timeouts, in microsecond ticks.
`define SSR_LATE_TO_RST 16'h03e8
`define SSR_CUT_TO_RST 16'h0fa0
// Timing: clock period and timeout tick period, in ns.
`define SSR_CLK_NS 20
`define SSR_TICK_NS 1000
// Bus responses.
`define SSR_RESP_OKAY 2'b00
`define SSR_RESP_SLVERR 2'b10
`endif

// ### bench/ssr_sr_asserts.sv
// Concurrent checks on the ports of the service-request collector.
// Assumes the register map of ssr_regs.vh and a single core_clk domain.
`timescale 1ns/1ps
`include "ssr_regs.vh"
module ssr_sr_asserts (
  input wire core_clk,
  input wire rst_b,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [1:0] s_axi_bresp,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire irq_n_out,
  input wire irq_n_oe
);
  // A write beat taken on either channel may clear a source.
  wire wr_take = (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin and bus handshake relations.
  AST_IRQ_OUT_LOW: assert property (!irq_n_out)
    else $error("interrupt data not low");
  AST_IRQ_OE_RESET: assert property ($rose(rst_b) |-> !irq_n_oe ##1 !irq_n_oe)
    else $error("interrupt driven just after reset");
  AST_IRQ_FALL: assert property ($fell(irq_n_oe) && $past(rst_b)
    |-> $past(wr_take, 2) || $past(wr_take, 3))
    else $error("interrupt released without a write");
  AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_R_AFTER: assert property (ar_take |=> s_axi_rvalid)
    else $error("read data late");
  AST_AW_REFUSE: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("write address accepted too soon");
  AST_AR_REFUSE: assert property (ar_take |=> !s_axi_arready [*2])
    else $error("read address accepted too soon");
  AST_RD_UNMAPPED: assert property (ar_take && s_axi_araddr >= 8'h38 && s_axi_araddr <= 8'h3f
    |=> s_axi_rresp == `SSR_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered wrongly");
  // Main scenarios reached.
  COV_IRQ: cover property ($rose(irq_n_oe));
  COV_BERR: cover property (s_axi_bvalid && s_axi_bresp == `SSR_RESP_SLVERR);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule // ssr_sr_asserts

bind ssr_service_request ssr_sr_asserts i_chk (.core_clk(core_clk), .rst_b(rst_b),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bresp(s_axi_bresp), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq_n_out(irq_n_out),
  .irq_n_oe(irq_n_oe));

// ### bench/testbench.sv
// Self-checking bench for the service-request collector.
// Assumes the register map of ssr_regs.vh and a 50 MHz core clock.
`timescale 1ns/1ps
`include "ssr_regs.vh"
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, irq_n_out, irq_n_oe;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [28:0] ev = '0;
  logic [7:0] parr = '0, los = '0, obuf = '0, simp = '0, perm = '0, vi = 8'h00;
  logic [39:0] uch = '0;
  logic va = 1'b0;
  logic [2:0] upn = 3'h5;
  logic [9:0] sad = 10'h2a5;
  logic [28:0] r_ev [29];
  logic [7:0] r_a [29];
  logic [31:0] r_e [29];
  int miscompares = 0, cmp_count = 0;
  // Free-running core clock.
  always #10 core_clk = ~core_clk;
  ssr_service_request i_dut (.core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_parity_err(ev[0]), .cell_cnt_roll(ev[1]), .parity_cnt_roll(ev[2]),
    .tx_data_empty(ev[3]), .rx_data_arrive(ev[4]), .rx_data_overrun(ev[5]),
    .rx_data_half(ev[6]), .rx_data_roll(ev[7]), .unst_roll(ev[16:8]), .unst_roll_port(upn),
    .strc_roll(ev[26:17]), .strc_ptr_oor(ev[27]), .strc_sig_changed(ev[28]),
    .strc_struct_addr(sad), .vc_cell_arrive(va), .vc_cell_index(vi),
    .unst_port_arrive(parr), .port_los(los), .port_obuf_err(obuf),
    .port_simple_under(simp), .port_perm_under(perm), .port_under_chan(uch),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
  ////////////////////////////////////////////////////////////////////////////
  // Comparison and reporting.
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Bus master: each channel is released once its ready is sampled high.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rdr(input logic [7:0] a, input logic [1:0] er = 2'b00);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  // One-cycle event pulses, then time for the interrupt to follow.
  task automatic pulse(input logic [28:0] v);
    @(posedge core_clk);
    ev <= v;
    @(posedge core_clk);
    ev <= '0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic pp(input logic [7:0] v);
    @(posedge core_clk);
    {los, obuf, simp, perm} <= {v, v, v, v};
    @(posedge core_clk);
    {los, obuf, simp, perm} <= '0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic irq(input logic e);
    @(negedge core_clk);
    chk("irq_n_oe", {31'h0, irq_n_oe}, {31'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: table of event sources, then the awkward cases.
  initial begin
    for (int i = 0; i < 29; i++) begin
      r_ev[i] = 29'h1 << i;
      r_a[i] = i < 8 ? `SSR_STAT_MISC : (i < 17 ? `SSR_STAT_UNST : `SSR_STAT_STRC);
      r_e[i] = 32'h1 << (i < 8 ? i : (i < 17 ? i - 8 : i - 17));
    end
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    rdr(`SSR_LATE_TO);
    chk("late_to", rd, 32'h3e8);
    rdr(`SSR_CUT_TO);
    chk("cut_to", rd, 32'hfa0);
    pulse(r_ev[28]);
    rdr(`SSR_STAT_STRC);
    chk("sig_off", rd, 32'h0);
    wr(`SSR_EN_MISC, 32'hff);
    wr(`SSR_EN_UNST, 32'h1ff);
    wr(`SSR_EN_STRC, 32'hfff);
    wr(`SSR_CTRL, 32'h1);
    for (int i = 0; i < 29; i++) begin
      pulse(r_ev[i]);
      rdr(r_a[i]);
      chk("status", rd, r_e[i]);
      irq(1'b1);
      wr(r_a[i], r_e[i]);
      irq(1'b0);
      rdr(r_a[i]);
      chk("cleared", rd, 32'h0);
    end
    rdr(`SSR_LAST_UNST);
    chk("last_unst", rd, 32'h5);
    rdr(`SSR_LAST_STRC);
    chk("last_strc", rd, 32'h2a5);
    // A rollover whose enable is clear must leave the records alone.
    upn <= 3'h2;
    sad <= 10'h155;
    wr(`SSR_EN_UNST, 32'h0);
    wr(`SSR_EN_STRC, 32'h0);
    pulse(r_ev[8] | r_ev[17]);
    rdr(`SSR_LAST_UNST);
    chk("last_unst_hold", rd, 32'h5);
    rdr(`SSR_LAST_STRC);
    chk("last_strc_hold", rd, 32'h2a5);
    $display("done: source table");
    wr(`SSR_EN_MISC, 32'h0);
    pulse(r_ev[0]);
    irq(1'b0);
    wr(`SSR_EN_MISC, 32'hff);
    repeat (2) @(posedge core_clk);
    irq(1'b1);
    wr(`SSR_STAT_MISC, 32'h1);
    @(posedge core_clk);
    va <= 1'b1;
    vi <= 8'h9c;
    @(posedge core_clk);
    va <= 1'b0;
    wr(`SSR_ARRIVAL, 32'h9c);
    rdr(`SSR_ARRIVAL);
    chk("arrival", rd, 32'h19c);
    wr(`SSR_ARRIVAL, 32'h8000009c);
    rdr(`SSR_ARRIVAL);
    chk("arrival_clr", rd, 32'h9c);
    $display("done: mask and arrival");
    wr({`SSR_PORT_EN, 5'd8}, 32'h7f);
    pp(8'h04);
    rdr({`SSR_PORT_STAT, 5'd8});
    chk("port_unst", rd, 32'h03);
    irq(1'b1);
    wr({`SSR_PORT_STAT, 5'd8}, 32'h7f);
    wr(`SSR_PORT_MODE, 32'h04);
    uch <= 40'h11 << 10;
    pp(8'h04);
    rdr({`SSR_PORT_STAT, 5'd8});
    chk("port_strc", rd, 32'h1c);
    rdr({`SSR_PORT_SIMPLE, 5'd8});
    chk("simple_ch", rd, 32'h11);
    rdr({`SSR_PORT_PERM, 5'd8});
    chk("perm_map", rd, 32'h20000);
    wr({`SSR_PORT_PERM, 5'd8}, 32'h20000);
    rdr({`SSR_PORT_PERM, 5'd8});
    chk("perm_clr", rd, 32'h0);
    $display("done: port alarms");
    wr(`SSR_LATE_TO, 32'h2);
    wr(`SSR_CUT_TO, 32'h4);
    @(posedge core_clk);
    parr <= 8'hff;
    @(posedge core_clk);
    parr <= 8'h00;
    repeat (120) @(posedge core_clk);
    rdr({`SSR_PORT_STAT, 5'd0});
    chk("late", rd, 32'h40);
    repeat (120) @(posedge core_clk);
    rdr({`SSR_PORT_STAT, 5'd0});
    chk("cut", rd, 32'h60);
    rdr(8'h38, `SSR_RESP_SLVERR);
    chk("unmapped", rd, 32'h0);
    wr(8'h38, 32'hffff, `SSR_RESP_SLVERR);
    $display("done: timeouts and unmapped");
    report_and_stop;
  end
  // Watchdog cuts a hang short.
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    report_and_stop;
  end
endmodule // testbench
